// File: hdl/flash_sp_dev.sv
// Purpose: Self-programming sequencer on the flash side
// Assumes: Flash macro reports op_done_i on mclk_i
// Notes: Programming time comes from the macro, not here
`timescale 1ns/1ps
module flash_sp_dev
  import flash_sp_pkg::*;
#(
  parameter int PAGE_WORDS = PAGE_WORDS_DOC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  flash_sp_if.dev link,
  input wire logic [1:0] boot_sel_i,
  input wire logic op_done_i,
  input wire logic [WORD_IDX_W-1:0] buf_rd_idx_i,
  output logic [15:0] buf_rd_data_o,
  output logic page_op_req_o,
  output logic page_op_erase_o,
  output logic [PAGE_W-1:0] page_idx_o,
  output logic rd_req_o,
  output logic [PC_W-1:0] rd_waddr_o,
  output logic rd_byte_hi_o,
  output logic [15:0] boot_start_o,
  output logic [5:0] boot_pages_o
);
  // Buffer depth must match the seven-bit in-page index
  if (PAGE_WORDS != (1 << WORD_IDX_W)) begin : g_depth_check
    $error("PAGE_WORDS must match the in-page index width");
  end

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_ARMED = 3'b010,
    S_BUSY = 3'b100
  } dev_state_t;

  dev_state_t state_reg, state_next;
  logic [2:0] cnt_reg;
  logic [4:0] cmd_reg;
  logic rww_busy_reg;
  logic op_rww_reg;
  logic [15:0] page_buf [PAGE_WORDS];
  logic [15:0] buf_rd_data_reg;
  logic page_op_req_reg;
  logic page_op_erase_reg;
  logic [PAGE_W-1:0] page_idx_reg;
  logic rd_req_reg;
  logic [PC_W-1:0] rd_waddr_reg;
  logic rd_byte_hi_reg;
  logic [15:0] boot_start_reg;
  logic [5:0] boot_pages_reg;
  logic [7:0] ctrl_rdata_reg;
  logic cpu_halt_reg;

  // Word address bit 15 lives in the extension register
  wire [16:0] full_ptr = {link.addr_ext[0], link.z_ptr};
  // Page index is word address bits 15..7
  wire [PAGE_W-1:0] ptr_page = full_ptr[16:8];
  // Seven in-page bits pick one of the page's words
  // Fill index skips bit 0, the byte select
  wire [WORD_IDX_W-1:0] ptr_word = full_ptr[7:1];
  wire page_in_rww = ptr_page < RWW_PAGES;
  wire cmd_en = link.ctrl_wdata[EN_BIT];
  // Pending EEPROM writes block control writes entirely
  wire take_cmd = link.ctrl_wr && cmd_en && !link.eeprom_write_busy
    && (state_reg == S_IDLE);
  wire is_erase = cmd_reg[ERASE_BIT];
  wire is_write = cmd_reg[WRITE_BIT];
  wire is_lock = cmd_reg[LOCK_BIT];
  wire is_reen = cmd_reg[REEN_BIT];
  wire is_fill = !is_erase && !is_write && !is_lock && !is_reen;
  wire armed = state_reg == S_ARMED;
  // Store may land on edges one to four after the take, load one to three
  wire spm_hit = armed && link.spm_exec;
  wire lpm_hit = armed && is_lock && link.lpm_exec
    && (cnt_reg < 3'(LPM_WINDOW));
  wire window_out = armed && (cnt_reg == 3'(SPM_WINDOW - 1));
  wire page_go = spm_hit && (is_erase || is_write);
  wire fill_go = spm_hit && is_fill;
  wire reen_go = spm_hit && is_reen;
  wire plain_lpm = link.lpm_exec && !(armed && is_lock);

  // Boot section decode
  wire sel_512 = boot_sel_i == BOOT_SEL_512;
  wire sel_1k = boot_sel_i == BOOT_SEL_1K;
  wire sel_2k = boot_sel_i == BOOT_SEL_2K;
  wire [15:0] boot_start_d = sel_512 ? BOOT_START_512 :
    sel_1k ? BOOT_START_1K :
    sel_2k ? BOOT_START_2K : BOOT_START_4K;
  wire [5:0] boot_pages_d = sel_512 ? BOOT_PAGES_512 :
    sel_1k ? BOOT_PAGES_1K :
    sel_2k ? BOOT_PAGES_2K : BOOT_PAGES_4K;

  // Status is registered, so the core reads it one cycle late
  wire [7:0] status_d = {1'b0, rww_busy_reg, 1'b0, cmd_reg[REEN_BIT],
    cmd_reg[LOCK_BIT], cmd_reg[WRITE_BIT], cmd_reg[ERASE_BIT],
    state_reg != S_IDLE};

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: begin
        if (take_cmd) begin
          state_next = S_ARMED;
        end
      end
      S_ARMED: begin
        if (page_go) begin
          state_next = S_BUSY;
        end else if (spm_hit || lpm_hit || window_out) begin
          state_next = S_IDLE;
        end
      end
      S_BUSY: begin
        // Enable stays up until the macro finishes
        if (op_done_i) begin
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_reg <= S_IDLE;
      cnt_reg <= 3'h0;
      cmd_reg <= 5'h00;
      op_rww_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= take_cmd ? 3'h0 : (armed ? cnt_reg + 3'h1 : cnt_reg);
      if (take_cmd) begin
        cmd_reg <= link.ctrl_wdata[REEN_BIT:0];
      end else if (state_next == S_IDLE) begin
        cmd_reg <= 5'h00;
      end
      if (page_go) begin
        op_rww_reg <= page_in_rww;
      end
    end
  end

  // A new erase or write sets busy; that wins over re-enable
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rww_busy_reg <= 1'b0;
    end else if (page_go) begin
      rww_busy_reg <= 1'b1;
    end else if (reen_go) begin
      rww_busy_reg <= 1'b0;
    end
  end

  // Buffer has no reset; software refills it before every write
  // Buffer write ignores pointer bit 0
  always_ff @(posedge mclk_i) begin
    if (fill_go) begin
      page_buf[ptr_word] <= link.word_data;
    end
    buf_rd_data_reg <= page_buf[buf_rd_idx_i];
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      page_op_req_reg <= 1'b0;
      page_op_erase_reg <= 1'b0;
      page_idx_reg <= '0;
      rd_req_reg <= 1'b0;
      rd_waddr_reg <= '0;
      rd_byte_hi_reg <= 1'b0;
      boot_start_reg <= BOOT_START_4K;
      boot_pages_reg <= BOOT_PAGES_4K;
      ctrl_rdata_reg <= CTRL_RESET;
      cpu_halt_reg <= 1'b0;
    end else begin
      page_op_req_reg <= page_go;
      if (page_go) begin
        page_op_erase_reg <= is_erase;
        page_idx_reg <= ptr_page;
      end
      // Plain reads pass through whenever no lock read is armed
      rd_req_reg <= plain_lpm;
      if (plain_lpm) begin
        rd_waddr_reg <= full_ptr[16:1];
        rd_byte_hi_reg <= full_ptr[0];
      end
      boot_start_reg <= boot_start_d;
      boot_pages_reg <= boot_pages_d;
      ctrl_rdata_reg <= status_d;
      // Only STALLED_READ_REGION targets stop the core; CONCURRENT_READ_REGION ops run beside code
      cpu_halt_reg <= (state_next == S_BUSY)
        && !(page_go ? page_in_rww : op_rww_reg);
    end
  end

  assign buf_rd_data_o = buf_rd_data_reg;
  assign page_op_req_o = page_op_req_reg;
  assign page_op_erase_o = page_op_erase_reg;
  assign page_idx_o = page_idx_reg;
  assign rd_req_o = rd_req_reg;
  assign rd_waddr_o = rd_waddr_reg;
  assign rd_byte_hi_o = rd_byte_hi_reg;
  assign boot_start_o = boot_start_reg;
  assign boot_pages_o = boot_pages_reg;
  assign link.ctrl_rdata = ctrl_rdata_reg;
  assign link.cpu_halt = cpu_halt_reg;
endmodule

// File: hdl/flash_sp_pkg.sv
// Purpose: Shared constants for flash self-programming sequencing
// Assumes: One core clock, synchronous active-low reset
// Notes: Control register bit layout is shared by both ends
package flash_sp_pkg;
  localparam int CTRL_W = 8;
  localparam int EN_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int WRITE_BIT = 2;
  localparam int LOCK_BIT = 3;
  localparam int REEN_BIT = 4;
  localparam int BUSY_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int PC_W = 16;
  localparam int PAGE_W = 9;
  localparam int WORD_IDX_W = 7;
  localparam int PAGE_WORDS_DOC = 128;
  localparam logic [PAGE_W-1:0] RWW_PAGES = 9'h1e0;
  localparam int SPM_WINDOW = 4;
  localparam int LPM_WINDOW = 3;
  localparam logic [15:0] BOOT_START_512 = 16'hfe00;
  localparam logic [15:0] BOOT_START_1K = 16'hfc00;
  localparam logic [15:0] BOOT_START_2K = 16'hf800;
  localparam logic [15:0] BOOT_START_4K = 16'hf000;
  localparam logic [5:0] BOOT_PAGES_512 = 6'h04;
  localparam logic [5:0] BOOT_PAGES_1K = 6'h08;
  localparam logic [5:0] BOOT_PAGES_2K = 6'h10;
  localparam logic [5:0] BOOT_PAGES_4K = 6'h20;
  localparam logic [1:0] HCMD_FILL = 2'h0;
  localparam logic [1:0] HCMD_ERASE = 2'h1;
  localparam logic [1:0] HCMD_WRITE = 2'h2;
  localparam logic [1:0] HCMD_REEN = 2'h3;
  localparam logic [1:0] BOOT_SEL_512 = 2'h3;
  localparam logic [1:0] BOOT_SEL_1K = 2'h2;
  localparam logic [1:0] BOOT_SEL_2K = 2'h1;
  localparam logic [7:0] CTRL_FILL = 8'h01;
  localparam logic [7:0] CTRL_ERASE = 8'h03;
  localparam logic [7:0] CTRL_WRITE = 8'h05;
  localparam logic [7:0] CTRL_REEN = 8'h11;
endpackage

// File: hdl/flash_sp_if.sv
// Purpose: Core-to-sequencer link for self-programming
// Assumes: Both ends on mclk_i
// Notes: Host drives commands, device drives status
`timescale 1ns/1ps
interface flash_sp_if (
  input wire logic mclk_i,
  input wire logic rst_n_i
);
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_rdata;
  logic spm_exec;
  logic lpm_exec;
  logic [15:0] z_ptr;
  logic [7:0] addr_ext;
  logic [15:0] word_data;
  logic eeprom_write_busy;
  logic cpu_halt;
  modport dev (
    input ctrl_wr, ctrl_wdata, spm_exec, lpm_exec, z_ptr, addr_ext,
    input word_data, eeprom_write_busy,
    output ctrl_rdata, cpu_halt
  );
  modport host (
    output ctrl_wr, ctrl_wdata, spm_exec, lpm_exec, z_ptr, addr_ext,
    output word_data, eeprom_write_busy,
    input ctrl_rdata, cpu_halt
  );
endinterface

// File: hdl/flash_sp_host.sv
// Purpose: Core-side command issuer for self-programming
// Assumes: Device answers on the same clock
// Notes: Keeps its own fill pointer so callers pass pages only
`timescale 1ns/1ps
module flash_sp_host
  import flash_sp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  flash_sp_if.host link,
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_code_i,
  input wire logic [16:0] cmd_ptr_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic eeprom_busy_i,
  input wire logic rd_req_i,
  input wire logic [16:0] rd_ptr_i,
  output logic cmd_ready_o,
  output logic irq_hold_o,
  output logic rww_busy_o
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_POLL = 4'b0010,
    H_ARM = 4'b0100,
    H_FIRE = 4'b1000
  } host_state_t;

  host_state_t state_reg, state_next;
  logic [7:0] cmd_val_reg;
  logic [16:0] ptr_reg;
  logic [16:0] fill_ptr_reg;
  logic [15:0] data_reg;
  logic ctrl_wr_reg;
  logic spm_reg;
  logic lpm_reg;
  logic eeb_reg;
  logic ready_reg;
  logic irq_hold_reg;
  logic rww_busy_reg;

  wire take = (state_reg == H_IDLE) && cmd_valid_i;
  wire take_rd = (state_reg == H_IDLE) && !cmd_valid_i && rd_req_i;
  // Poll until enable clears and EEPROM is idle
  wire may_go = !link.ctrl_rdata[EN_BIT] && !eeprom_busy_i;
  wire is_fill = cmd_code_i == HCMD_FILL;
  wire [7:0] cmd_val_d = (cmd_code_i == HCMD_ERASE) ? CTRL_ERASE :
    (cmd_code_i == HCMD_WRITE) ? CTRL_WRITE :
    (cmd_code_i == HCMD_REEN) ? CTRL_REEN : CTRL_FILL;
  // Page ops start at word 0 with byte select low
  wire [16:0] page_ptr = {cmd_ptr_i[16:8], 8'h00};

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      H_IDLE: if (take) state_next = H_POLL;
      H_POLL: if (may_go) state_next = H_ARM;
      H_ARM: state_next = H_FIRE;
      H_FIRE: state_next = H_IDLE;
      default: state_next = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_reg <= H_IDLE;
      cmd_val_reg <= CTRL_RESET;
      ptr_reg <= '0;
      fill_ptr_reg <= '0;
      data_reg <= 16'h0000;
      ctrl_wr_reg <= 1'b0;
      spm_reg <= 1'b0;
      lpm_reg <= 1'b0;
      eeb_reg <= 1'b0;
      ready_reg <= 1'b0;
      irq_hold_reg <= 1'b0;
      rww_busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_wr_reg <= state_next == H_ARM;
      // Store follows the control write one cycle later
      spm_reg <= state_next == H_FIRE;
      lpm_reg <= take_rd;
      eeb_reg <= eeprom_busy_i;
      ready_reg <= state_next == H_IDLE;
      irq_hold_reg <= state_next != H_IDLE;
      rww_busy_reg <= link.ctrl_rdata[BUSY_BIT];
      if (take) begin
        cmd_val_reg <= cmd_val_d;
        data_reg <= cmd_data_i;
        ptr_reg <= is_fill ? fill_ptr_reg : page_ptr;
        if (is_fill) begin
          fill_ptr_reg <= fill_ptr_reg + 17'h2;
        end else if (cmd_code_i == HCMD_ERASE) begin
          fill_ptr_reg <= page_ptr;
        end
      end else if (take_rd) begin
        ptr_reg <= rd_ptr_i;
      end
    end
  end

  assign link.ctrl_wr = ctrl_wr_reg;
  assign link.ctrl_wdata = cmd_val_reg;
  assign link.spm_exec = spm_reg;
  assign link.lpm_exec = lpm_reg;
  assign link.z_ptr = ptr_reg[15:0];
  assign link.addr_ext = {7'h00, ptr_reg[16]};
  assign link.word_data = data_reg;
  assign link.eeprom_write_busy = eeb_reg;
  assign cmd_ready_o = ready_reg;
  assign irq_hold_o = irq_hold_reg;
  assign rww_busy_o = rww_busy_reg;
endmodule

// File: tb/flash_sp_props.sv
// Purpose: Link checks between core issuer and flash sequencer
// Assumes: One clock, synchronous active-low reset
// Notes: Page op completion is not visible here, only inferred
`timescale 1ns/1ps
module flash_sp_props
  import flash_sp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic spm_exec,
  input wire logic lpm_exec,
  input wire logic [15:0] z_ptr,
  input wire logic [7:0] addr_ext,
  input wire logic [15:0] word_data,
  input wire logic eeprom_write_busy,
  input wire logic cpu_halt
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_spm_follows_wr: assert property (
    ctrl_wr |=> spm_exec && !ctrl_wr)
    else $error("store did not follow control write");
  a_wr_when_idle: assert property (
    ctrl_wr |-> !ctrl_rdata[EN_BIT])
    else $error("control write while enable set");
  a_wr_ee_clear: assert property (
    ctrl_wr |-> !eeprom_write_busy)
    else $error("control write while eeprom busy");
  a_enable_shown: assert property (
    ctrl_wr && ctrl_wdata[EN_BIT] |-> ##[1:2] ctrl_rdata[EN_BIT])
    else $error("enable not shown after write");
  a_fill_done: assert property (
    ctrl_wr && ctrl_wdata == 8'h01 |-> ##[2:4] !ctrl_rdata[EN_BIT])
    else $error("fill did not finish");
  a_page_op_busy: assert property (
    ctrl_wr && (ctrl_wdata[ERASE_BIT] || ctrl_wdata[WRITE_BIT])
    |-> ##[1:3] (ctrl_rdata[EN_BIT] && ctrl_rdata[BUSY_BIT]))
    else $error("page op not busy");
  a_busy_cleared_by: assert property (
    $fell(ctrl_rdata[BUSY_BIT]) |-> $past(spm_exec, 1) ||
    $past(spm_exec, 2) || $past(spm_exec, 3))
    else $error("rww busy cleared without store");
  a_halt_cause: assert property (
    $rose(cpu_halt) |-> $past(spm_exec, 1) || $past(spm_exec, 2))
    else $error("halt without page op");
  a_z0_clear: assert property (
    spm_exec |-> !z_ptr[0])
    else $error("pointer bit 0 set on store");
  a_write_word0: assert property (
    ctrl_wr && ctrl_wdata[WRITE_BIT] |=> z_ptr[7:0] == 8'h00)
    else $error("page write with nonzero word index");
  a_cmd_expires: assert property (
    ctrl_wr && ctrl_wdata[EN_BIT] && !ctrl_wdata[ERASE_BIT]
    && !ctrl_wdata[WRITE_BIT] |-> ##[2:6] !ctrl_rdata[EN_BIT])
    else $error("armed command did not clear");
endmodule

// File: tb/flash_self_program_addressing_test.sv
// Purpose: Drives both link ends, models page ops and buffer
// Assumes: Bench stands in for the flash macro done pulse
// Notes: Macro time is a few cycles to keep the run short
`timescale 1ns/1ps
module flash_self_program_addressing_test;
  import flash_sp_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_code_i = 2'h0;
  logic [16:0] cmd_ptr_i = 17'h00000;
  logic [15:0] cmd_data_i = 16'h0000;
  logic eeprom_busy_i = 1'b0;
  logic rd_req_i = 1'b0;
  logic [16:0] rd_ptr_i = 17'h00000;
  logic [1:0] boot_sel_i = 2'h0;
  logic op_done_i = 1'b0;
  logic [WORD_IDX_W-1:0] buf_rd_idx_i = 7'h00;
  logic cmd_ready_o, rww_busy_o, page_op_req_o, page_op_erase_o;
  logic irq_hold_o;
  logic rd_req_o, rd_byte_hi_o;
  logic [15:0] buf_rd_data_o, boot_start_o;
  logic [PAGE_W-1:0] page_idx_o;
  logic [PC_W-1:0] rd_waddr_o;
  logic [5:0] boot_pages_o;
  int bad_count = 0;
  int tests_run = 0;
  int op_seen = 0;
  int wr_seen = 0;
  int model_buf [128];
  int op_q [$];
  int rd_q [$];
  int i, n, pg, pass;
  logic [16:0] p;
  always #2 mclk_i = ~mclk_i;
  flash_sp_if u_flash_sp_if (.mclk_i(mclk_i), .rst_n_i(rst_n_i));
  flash_sp_host u_flash_sp_host (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .link(u_flash_sp_if), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .cmd_ptr_i(cmd_ptr_i),
    .cmd_data_i(cmd_data_i), .eeprom_busy_i(eeprom_busy_i),
    .rd_req_i(rd_req_i), .rd_ptr_i(rd_ptr_i), .cmd_ready_o(cmd_ready_o),
    .irq_hold_o(irq_hold_o), .rww_busy_o(rww_busy_o));
  flash_sp_dev u_flash_sp_dev (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .link(u_flash_sp_if), .boot_sel_i(boot_sel_i), .op_done_i(op_done_i),
    .buf_rd_idx_i(buf_rd_idx_i), .buf_rd_data_o(buf_rd_data_o),
    .page_op_req_o(page_op_req_o), .page_op_erase_o(page_op_erase_o),
    .page_idx_o(page_idx_o), .rd_req_o(rd_req_o), .rd_waddr_o(rd_waddr_o),
    .rd_byte_hi_o(rd_byte_hi_o), .boot_start_o(boot_start_o),
    .boot_pages_o(boot_pages_o));
  flash_sp_props u_flash_sp_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .ctrl_wr(u_flash_sp_if.ctrl_wr), .ctrl_wdata(u_flash_sp_if.ctrl_wdata),
    .ctrl_rdata(u_flash_sp_if.ctrl_rdata),
    .spm_exec(u_flash_sp_if.spm_exec), .lpm_exec(u_flash_sp_if.lpm_exec),
    .z_ptr(u_flash_sp_if.z_ptr), .addr_ext(u_flash_sp_if.addr_ext),
    .word_data(u_flash_sp_if.word_data), .cpu_halt(u_flash_sp_if.cpu_halt),
    .eeprom_write_busy(u_flash_sp_if.eeprom_write_busy));
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic hang();
    bad_count++;
    close_out();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Model side: every page op and plain read is checked as it leaves
  always @(posedge mclk_i) begin
    if (rst_n_i && u_flash_sp_if.ctrl_wr === 1'b1) begin
      wr_seen++;
      chk(irq_hold_o, 1);
    end
    if (rst_n_i && u_flash_sp_if.spm_exec === 1'b1) begin
      chk(irq_hold_o, 1);
    end
    if (rst_n_i && page_op_req_o === 1'b1) begin
      op_seen++;
      chk({page_op_erase_o, page_idx_o}, op_q.pop_front());
    end
    if (rst_n_i && rd_req_o === 1'b1) begin
      chk({rd_waddr_o, rd_byte_hi_o}, rd_q.pop_front());
    end
  end
  // Leading wait keeps valid from being driven twice in one step
  task automatic cmd(input logic [1:0] c, input logic [16:0] a,
                     input logic [15:0] d);
    int k;
    @(negedge mclk_i);
    cmd_valid_i = 1'b1;
    cmd_code_i = c;
    cmd_ptr_i = a;
    cmd_data_i = d;
    for (k = 0; k < 300 && cmd_ready_o !== 1'b1; k++) @(negedge mclk_i);
    if (cmd_ready_o !== 1'b1) hang();
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
  endtask
  task automatic finish_op(input int target, input int cnt);
    int k;
    for (k = 0; k < 200 && op_seen < cnt; k++) @(negedge mclk_i);
    if (op_seen < cnt) hang();
    repeat (2) @(negedge mclk_i);
    chk(u_flash_sp_if.cpu_halt, target >= 480);
    repeat (3) @(negedge mclk_i);
    op_done_i = 1'b1;
    @(negedge mclk_i);
    op_done_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    if (target < 480) chk(rww_busy_o, 1);
  endtask
  task automatic reen(input logic [16:0] a);
    int k;
    cmd(HCMD_REEN, a, 16'h0000);
    for (k = 0; k < 50 && rww_busy_o !== 1'b0; k++) @(negedge mclk_i);
    chk(rww_busy_o, 0);
    if (rww_busy_o !== 1'b0) close_out();
    chk(irq_hold_o, 0);
  endtask
  initial begin
    void'($urandom(32'h310a6dbe));
    repeat (6) @(negedge mclk_i);
    rst_n_i = 1'b1;
    for (i = 0; i < 4; i++) begin
      boot_sel_i = i[1:0];
      repeat (2) @(negedge mclk_i);
      chk(boot_start_o, 32'h10000 - (512 << (3 - i)));
      chk(boot_pages_o, 4 << (3 - i));
    end
    $display("test boot size done");
    eeprom_busy_i = 1'b1;
    n = wr_seen;
    cmd(HCMD_FILL, 17'h00000, 16'h0000);
    repeat (20) @(negedge mclk_i);
    chk(wr_seen, n);
    eeprom_busy_i = 1'b0;
    repeat (20) @(negedge mclk_i);
    chk(wr_seen, n + 1);
    $display("test eeprom block done");
    for (i = 0; i < 4; i++) begin
      @(negedge mclk_i);
      rd_ptr_i = 17'($urandom_range(131071, 0));
      rd_q.push_back(rd_ptr_i);
      rd_req_i = 1'b1;
      @(negedge mclk_i);
      rd_req_i = 1'b0;
      repeat (6) @(negedge mclk_i);
    end
    chk(rd_q.size(), 0);
    $display("test plain read done");
    n = 0;
    for (pass = 0; pass < 2; pass++) begin
      pg = pass == 0 ? $urandom_range(479, 0) : $urandom_range(511, 480);
      p = {pg[8:0], 8'h00};
      op_q.push_back({1'b1, pg[8:0]});
      cmd(HCMD_ERASE, p, 16'h0000);
      n++;
      finish_op(pg, n);
      reen(p);
      for (i = 0; i < PAGE_WORDS_DOC; i++) begin
        model_buf[i] = $urandom_range(65535, 0);
        cmd(HCMD_FILL, p, model_buf[i][15:0]);
      end
      op_q.push_back({1'b0, pg[8:0]});
      cmd(HCMD_WRITE, p, 16'h0000);
      n++;
      finish_op(pg, n);
      reen(p);
      for (i = 0; i < PAGE_WORDS_DOC; i++) begin
        buf_rd_idx_i = i[6:0];
        @(negedge mclk_i);
        chk(buf_rd_data_o, model_buf[i]);
      end
      $display("test page pass %0d done", pass);
    end
    chk(op_q.size(), 0);
    close_out();
  end
endmodule
